//--- src/filter_gain_config_register.v
`timescale 1ns/100ps
`include "filter_gain_defines.vh"

module filter_gain_config_register (
    // Clock and reset
    input  wire                   clk,
    input  wire                   rst_b,
    // Serial port pins
    input  wire                   latch_strobe,
    input  wire                   serial_clk,
    input  wire                   serial_data,
    output wire                   serial_readback_output,
    // Chip enable pin
    input  wire                   chip_on_pin,
    // Settings shared by both channels
    output wire [`CFG_WIDTH-1:0]  filter_gain_config,
    output wire [4:0]             corner_freq_mhz,
    output wire                   signal_present,
    output wire [2:0]             digital_gain_code,
    output wire [4:0]             pre_gain_db,
    output wire [4:0]             post_gain_db,
    output wire [4:0]             vga_max_gain_db,
    output wire                   chain_enable
);
    // ============================================================
    // Reset release.
    reg        rst_meta_reg;
    reg        rst_sync_reg;
    wire       rst_int_b = rst_sync_reg;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ============================================================
    // Pin synchronisers.
    wire [3:0] pins_sync;

    pin_sync #(
        .WIDTH    (4)
    ) u_pin_sync (
        .clk      (clk),
        .rst_b    (rst_int_b),
        .async_in ({chip_on_pin, serial_data, serial_clk, ~latch_strobe}),
        .sync_out (pins_sync)
    );

    // The strobe enters inverted so that the cleared synchroniser reads as an
    // idle high strobe; otherwise reset would look like a cycle opening.
    wire le_s    = ~pins_sync[0];
    wire sclk_s  = pins_sync[1];
    wire sdata_s = pins_sync[2];
    wire chip_s  = pins_sync[3];

    // ============================================================
    // Edge detection on the synchronised pins.
    // Edges are found by oversampling, so each serial clock half period must
    // last longer than one system clock or an edge is lost.
    reg        sclk_d_reg;
    reg        le_d_reg;
    wire       sclk_rise = sclk_s & ~sclk_d_reg;
    wire       sclk_fall = ~sclk_s & sclk_d_reg;
    wire       le_rise   = le_s & ~le_d_reg;

    // ============================================================
    // Transfer state machine.
    localparam ST_IDLE  = 2'b00;
    localparam ST_CMD   = 2'b01;
    localparam ST_WRITE = 2'b10;
    localparam ST_READ  = 2'b11;

    reg [1:0]              state_reg;
    reg [1:0]              state_next;
    reg [`CNT_WIDTH-1:0]   count_reg;
    reg [`CNT_WIDTH-1:0]   count_next;
    reg [`CFG_WIDTH-1:0]   shift_reg;
    reg [`CFG_WIDTH-1:0]   shift_next;
    reg [`CFG_WIDTH-1:0]   cfg_reg;
    reg [`CFG_WIDTH-1:0]   cfg_next;
    reg [`CFG_WIDTH-1:0]   rd_reg;
    reg [`CFG_WIDTH-1:0]   rd_next;
    reg                    sdo_reg;
    reg                    sdo_next;

    always @* begin
        state_next = state_reg;
        count_next = count_reg;
        shift_next = shift_reg;
        cfg_next   = cfg_reg;
        rd_next    = rd_reg;
        sdo_next   = sdo_reg;
        case (state_reg)
            ST_IDLE: begin
                if (!le_s) begin
                    state_next = ST_CMD;
                end
            end
            ST_CMD: begin
                // A strobe that rises before the command edge drops the cycle.
                if (le_s) begin
                    state_next = ST_IDLE;
                end else if (sclk_rise) begin
                    state_next = sdata_s ? ST_WRITE : ST_READ;
                    count_next = {`CNT_WIDTH{1'b0}};
                    rd_next    = cfg_reg;
                end
            end
            ST_WRITE: begin
                if (le_rise) begin
                    if (count_reg == `BIT_COUNT) begin
                        cfg_next = shift_reg;
                    end
                    state_next = ST_IDLE;
                end else if (sclk_rise && count_reg != `BIT_COUNT) begin
                    shift_next = {sdata_s, shift_reg[`CFG_WIDTH-1:1]};
                    count_next = count_reg + 4'h1;
                end
            end
            ST_READ: begin
                if (le_rise) begin
                    state_next = ST_IDLE;
                end else if (sclk_fall && count_reg != `BIT_COUNT) begin
                    sdo_next   = rd_reg[0];
                    rd_next    = {1'b0, rd_reg[`CFG_WIDTH-1:1]};
                    count_next = count_reg + 4'h1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            sclk_d_reg <= 1'b0;
            le_d_reg   <= 1'b1;
            state_reg  <= ST_IDLE;
            count_reg  <= {`CNT_WIDTH{1'b0}};
            shift_reg  <= `CFG_RESET;
            cfg_reg    <= `CFG_RESET;
            rd_reg     <= `CFG_RESET;
            sdo_reg    <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
            le_d_reg   <= le_s;
            state_reg  <= state_next;
            count_reg  <= count_next;
            shift_reg  <= shift_next;
            cfg_reg    <= cfg_next;
            rd_reg     <= rd_next;
            sdo_reg    <= sdo_next;
        end
    end

    // ============================================================
    // Decoded settings.
    // The decode reads the next stored value, so each output flop moves
    // on the same edge as the register and no output lags the others.
    reg [4:0]              freq_reg;
    reg [2:0]              code_reg;
    reg [4:0]              pre_db_reg;
    reg [4:0]              post_db_reg;
    reg [4:0]              vga_db_reg;

    always @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            freq_reg    <= 5'h00;
            code_reg    <= 3'h0;
            pre_db_reg  <= `PRE_GAIN_LO_DB;
            post_db_reg <= `POST_GAIN_LO_DB;
            vga_db_reg  <= `VGA_MAX_LO_DB;
        end else begin
            freq_reg    <= cfg_next[`FREQ_MSB:`FREQ_LSB];
            code_reg    <= cfg_next[`PRE_GAIN_BIT:`VGA_MAX_BIT];
            pre_db_reg  <= cfg_next[`PRE_GAIN_BIT] ? `PRE_GAIN_HI_DB : `PRE_GAIN_LO_DB;
            post_db_reg <= cfg_next[`POST_GAIN_BIT] ? `POST_GAIN_HI_DB : `POST_GAIN_LO_DB;
            vga_db_reg  <= cfg_next[`VGA_MAX_BIT] ? `VGA_MAX_HI_DB : `VGA_MAX_LO_DB;
        end
    end

    // One register feeds both channels; there is no per-channel copy to drift.
    // shared by both channels
    assign filter_gain_config     = cfg_reg;
    assign serial_readback_output = sdo_reg;
    assign signal_present         = chain_enable & (freq_reg != 5'h00);
    assign corner_freq_mhz        = freq_reg;
    assign digital_gain_code      = code_reg;
    assign pre_gain_db            = pre_db_reg;
    assign post_gain_db           = post_db_reg;
    assign vga_max_gain_db        = vga_db_reg;
    assign chain_enable           = chip_s;
endmodule

//--- src/filter_gain_defines.vh
`ifndef FILTER_GAIN_DEFINES_VH
`define FILTER_GAIN_DEFINES_VH

// ============================================================
// Register layout.
`define CFG_WIDTH        8
`define CFG_RESET        8'h00
`define FREQ_MSB         7
`define FREQ_LSB         3
`define PRE_GAIN_BIT     2
`define POST_GAIN_BIT    1
`define VGA_MAX_BIT      0

// ============================================================
// Serial framing.
`define BIT_COUNT        4'h8
`define CNT_WIDTH        4

// ============================================================
// Gain figures in dB.
`define PRE_GAIN_LO_DB   5'h03
`define PRE_GAIN_HI_DB   5'h06
`define POST_GAIN_LO_DB  5'h06
`define POST_GAIN_HI_DB  5'h0C
`define VGA_MAX_LO_DB    5'h16
`define VGA_MAX_HI_DB    5'h1C

`endif

//--- src/pin_sync.v
`timescale 1ns/100ps
`include "filter_gain_defines.vh"

// ============================================================
// Two-stage synchroniser, one per pin.
module pin_sync #(
    parameter WIDTH = 3
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_b,
    // Pins
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    stage1_reg[i] <= 1'b0;
                    stage2_reg[i] <= 1'b0;
                end else begin
                    stage1_reg[i] <= async_in[i];
                    stage2_reg[i] <= stage1_reg[i];
                end
            end
        end
    endgenerate

    assign sync_out = stage2_reg;
endmodule

//--- tb/filter_gain_config_register_monitor.sv
`timescale 1ns/100ps
// ============================================================
// Port checks of the configuration register.
module gain_cfg_monitor (
    // Clock and reset
    input       clk,
    input       rst_b,
    // Pins
    input       latch_strobe,
    input       serial_clk,
    input       chip_on_pin,
    input       serial_readback_output,
    // Settings
    input [7:0] filter_gain_config,
    input [4:0] corner_freq_mhz,
    input [2:0] digital_gain_code,
    input [4:0] pre_gain_db,
    input [4:0] post_gain_db,
    input [4:0] vga_max_gain_db,
    input       chain_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence quiet_strobe;
        !latch_strobe [*6];
    endsequence
    cfg_update_a:
        assert property (!$stable(filter_gain_config) |-> $past(latch_strobe, 2))
        else $error("config changed without strobe high");
    cfg_hold_a:
        assert property (quiet_strobe |-> $stable(filter_gain_config))
        else $error("config changed while strobe low");
    freq_code_a:
        assert property (corner_freq_mhz == filter_gain_config[7:3])
        else $error("frequency code mismatch");
    gain_code_a:
        assert property (digital_gain_code == filter_gain_config[2:0])
        else $error("gain code mismatch");
    pre_gain_a:
        assert property (pre_gain_db == (filter_gain_config[2] ? 5'h06 : 5'h03))
        else $error("preamp gain mismatch");
    post_vga_a:
        assert property ({post_gain_db, vga_max_gain_db} == {filter_gain_config[1] ?
            5'h0C : 5'h06, filter_gain_config[0] ? 5'h1C : 5'h16}) else $error("gain mismatch");
    chain_off_a:
        assert property (!chip_on_pin [*4] |-> !chain_enable) else $error("chain stays on");
    readback_edge_a:
        assert property (!$stable(serial_readback_output) |-> !$past(serial_clk, 2))
        else $error("readback moved off a falling edge");
endmodule
bind filter_gain_config_register gain_cfg_monitor u_gain_cfg_monitor (.clk, .rst_b,
    .latch_strobe, .serial_clk, .chip_on_pin, .serial_readback_output, .filter_gain_config,
    .corner_freq_mhz, .digital_gain_code, .pre_gain_db, .post_gain_db, .vga_max_gain_db,
    .chain_enable);

//--- tb/host_model.sv
`timescale 1ns/100ps
// ============================================================
// Host side of the serial port; the serial clock rests low between frames.
module host_model (
    // Clock
    input  logic clk,
    // Serial port
    output logic latch_strobe,
    output logic serial_clk,
    output logic serial_data,
    input  logic serial_readback_output
);
    real half = 62.5;
    initial begin
        latch_strobe = 1;
        serial_clk = 0;
        serial_data = 0;
    end
    task xfer(input logic wr, input logic [7:0] d, input int n, output logic [7:0] q);
        q = 8'h00;
        // The offset keeps every pin change away from the clk edges.
        @(posedge clk) #0.3;
        latch_strobe = 0;
        serial_data = wr;
        #half serial_clk = 1;
        #half serial_clk = 0;
        for (int i = 0; i < n; i++) begin
            serial_data = wr ? d[i] : ~serial_data;
            #half serial_clk = 1;
            q[i] = serial_readback_output;
            #half serial_clk = 0;
        end
        #half latch_strobe = 1;
        serial_data = ~serial_data;
        #half;
    endtask
endmodule

//--- tb/filter_gain_config_register_test.sv
`timescale 1ns/100ps
// ============================================================
// Bench signals.
module filter_gain_config_register_test;
    logic        clk = 0, rst_b = 0, chip_on_pin = 0;
    logic        latch_strobe, serial_clk, serial_data, serial_readback_output;
    logic        signal_present, chain_enable;
    logic [7:0]  filter_gain_config, q;
    logic [4:0]  corner_freq_mhz, pre_gain_db, post_gain_db, vga_max_gain_db;
    logic [2:0]  digital_gain_code;
    logic [27:0] rows [4];
    int          err_total = 0, cmp_count = 0;
    filter_gain_config_register u_filter_gain_config_register (.clk, .rst_b, .latch_strobe,
        .serial_clk, .serial_data, .serial_readback_output, .chip_on_pin, .filter_gain_config,
        .corner_freq_mhz, .signal_present, .digital_gain_code, .pre_gain_db, .post_gain_db,
        .vga_max_gain_db, .chain_enable);
    host_model u_host_model (.clk, .latch_strobe, .serial_clk, .serial_data,
        .serial_readback_output);
    initial begin
        forever #4 clk = ~clk;
    end
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task stop_test;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // A hang past about five times the expected run time ends it as a failure.
    initial begin
        #100000;
        err_total++;
        stop_test;
    end
    // ========================================================
    // Rows: written value, frequency, pre, post and VGA gains.
    initial begin
        rows[0] = {8'h07, 5'h00, 5'h06, 5'h0C, 5'h1C};
        rows[1] = {8'hF8, 5'h1F, 5'h03, 5'h06, 5'h16};
        rows[2] = {8'h0A, 5'h01, 5'h03, 5'h0C, 5'h16};
        rows[3] = {8'h85, 5'h10, 5'h06, 5'h06, 5'h1C};
        repeat (8) @(posedge clk);
        rst_b <= 1;
        repeat (4) @(posedge clk);
        chk("config", 8'h00, filter_gain_config);
        chk("pre", 8'h03, pre_gain_db);
        chip_on_pin <= 1;
        repeat (4) @(posedge clk);
        chk("enable", 8'h01, chain_enable);
        foreach (rows[i]) begin
            u_host_model.xfer(1, rows[i][27:20], 8, q);
            repeat (6) @(posedge clk);
            chk("config", rows[i][27:20], filter_gain_config);
            chk("freq", rows[i][19:15], corner_freq_mhz);
            chk("pre", rows[i][14:10], pre_gain_db);
            chk("post", rows[i][9:5], post_gain_db);
            chk("vga", rows[i][4:0], vga_max_gain_db);
            chk("code", rows[i][22:20], digital_gain_code);
            chk("present", rows[i][19:15] != 0, signal_present);
            u_host_model.xfer(0, 8'h00, 8, q);
            chk("readback", rows[i][27:20], q);
        end
        // ====================================================
        // Short write, slow host, chip off.
        u_host_model.xfer(1, 8'h55, 5, q);
        repeat (6) @(posedge clk);
        chk("short", 8'h85, filter_gain_config);
        u_host_model.half = 250;
        u_host_model.xfer(1, 8'hA3, 8, q);
        u_host_model.xfer(0, 8'h00, 8, q);
        chk("slow read", 8'hA3, q);
        chip_on_pin <= 0;
        repeat (5) @(posedge clk);
        chk("enable", 8'h00, chain_enable);
        chk("present", 8'h00, signal_present);
        stop_test;
    end
endmodule
